// ==== rtl/ccb_clock_config.sv ====
// clock configuration: serial rate, trim, PLL dividers, clock pin source
`timescale 1ns/1ns
module ccb_clock_config
(
	input  wire logic        core_clk_in,
	input  wire logic        reset_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic        pll_clk_in,
	input  wire logic [3:0]  counter_overflow_in,
	output logic      [7:0]  reg_rdata_out,
	output logic             baud_tick_out,
	output logic             char_slot_out,
	output logic      [7:0]  osc_freq_code_out,
	output logic             pll_power_down_out,
	output logic             pll_clock_valid_out,
	output logic      [4:0]  pll_feedback_factor_out,
	output logic      [7:0]  pll_output_factor_out,
	output logic             pll_div_reserved_out,
	output logic             clock_output_pin_out,
	output logic             clock_output_pin_oe_out
);

	logic [7:0]  host_serial_rate_q;
	logic [7:0]  slow_oscillator_trim_q;
	logic [7:0]  pll_and_clock_pin_control_q;
	logic [7:0]  pll_post_divider_q;
	logic [12:0] rate_period;
	logic [12:0] baud_cnt_q;
	logic [3:0]  frame_bit_q;
	logic        rate_write;
	logic        pll_sync1_q;
	logic        pll_sync2_q;
	logic [3:0]  xtal_div_q;
	logic [3:0]  overflow_sync1_q;
	logic [3:0]  overflow_sync2_q;
	logic [3:0]  overflow_prev_q;
	logic        overflow_toggle_q;
	logic [3:0]  clock_pin_source_select;
	logic        clock_pin_output_enable;
	logic        pll_power_down;
	logic        pin_level_d;
	logic        pin_oe_d;
	logic [12:0] gap_q;
	logic        rate_fresh_q;

	// cycles of one bit time for a given rate code
	function automatic logic [12:0] ccb_rate_period(input logic [7:0] code);
		logic [2:0]  rate_exponent;
		logic [4:0]  rate_mantissa;
		logic [12:0] base;
		rate_exponent = code[ccb_pkg::EXPONENT_MSB:ccb_pkg::EXPONENT_LSB];
		rate_mantissa = code[ccb_pkg::MANTISSA_MSB:0];
		if (rate_exponent == 3'h0)
		begin
			base = 13'(rate_mantissa) + 13'(ccb_pkg::MANTISSA_OFFSET_SMALL);
			ccb_rate_period = base;
		end
		else
		begin
			base = 13'(rate_mantissa) + 13'(ccb_pkg::MANTISSA_OFFSET_LARGE);
			ccb_rate_period = 13'(base << (rate_exponent - 3'h1));
		end
	endfunction : ccb_rate_period

	// feedback division factor for the two-bit setting
	function automatic logic [4:0] ccb_feedback(input logic [1:0] setting);
		case (setting)
			2'h0:    ccb_feedback = ccb_pkg::FEEDBACK_FACTOR_0;
			2'h1:    ccb_feedback = ccb_pkg::FEEDBACK_FACTOR_1;
			2'h2:    ccb_feedback = ccb_pkg::FEEDBACK_FACTOR_2;
			default: ccb_feedback = ccb_pkg::FEEDBACK_FACTOR_3;
		endcase
	endfunction : ccb_feedback

	assign clock_pin_source_select =
		pll_and_clock_pin_control_q[ccb_pkg::SELECT_MSB:ccb_pkg::SELECT_LSB];
	assign clock_pin_output_enable =
		pll_and_clock_pin_control_q[ccb_pkg::PIN_ENABLE_BIT];
	assign pll_power_down =
		pll_and_clock_pin_control_q[ccb_pkg::POWER_DOWN_BIT];
	assign rate_period = ccb_rate_period(host_serial_rate_q);
	assign rate_write  = reg_wr_in &&
		(reg_addr_in == ccb_pkg::ADDR_HOST_SERIAL_RATE);

	// register writes
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			host_serial_rate_q          <= ccb_pkg::RESET_HOST_SERIAL_RATE;
			slow_oscillator_trim_q      <= ccb_pkg::RESET_SLOW_OSC_TRIM;
			pll_and_clock_pin_control_q <= ccb_pkg::RESET_PLL_PIN_CONTROL;
			pll_post_divider_q          <= ccb_pkg::RESET_PLL_POST_DIVIDER;
		end
		else if (reg_wr_in)
		begin
			case (reg_addr_in)
				ccb_pkg::ADDR_HOST_SERIAL_RATE:
					host_serial_rate_q <= reg_wdata_in;
				ccb_pkg::ADDR_SLOW_OSC_TRIM:
					slow_oscillator_trim_q <= reg_wdata_in;
				ccb_pkg::ADDR_PLL_PIN_CONTROL:
					pll_and_clock_pin_control_q <= reg_wdata_in;
				ccb_pkg::ADDR_PLL_POST_DIVIDER:
					pll_post_divider_q <= reg_wdata_in;
				default:
					host_serial_rate_q <= host_serial_rate_q;
			endcase
		end
	end

	// register reads, one cycle after the strobe
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
			reg_rdata_out <= ccb_pkg::UNMAPPED_READ_VALUE;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				ccb_pkg::ADDR_HOST_SERIAL_RATE:
					reg_rdata_out <= host_serial_rate_q;
				ccb_pkg::ADDR_SLOW_OSC_TRIM:
					reg_rdata_out <= slow_oscillator_trim_q;
				ccb_pkg::ADDR_PLL_PIN_CONTROL:
					reg_rdata_out <= pll_and_clock_pin_control_q;
				ccb_pkg::ADDR_PLL_POST_DIVIDER:
					reg_rdata_out <= pll_post_divider_q;
				default:
					reg_rdata_out <= ccb_pkg::UNMAPPED_READ_VALUE;
			endcase
		end
	end

	// bit-rate generator; a new rate restarts the bit period
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in || rate_write)
		begin
			baud_cnt_q    <= 13'h0000;
			baud_tick_out <= 1'b0;
		end
		else if (baud_cnt_q >= rate_period - 13'h0001)
		begin
			baud_cnt_q    <= 13'h0000;
			baud_tick_out <= 1'b1;
		end
		else
		begin
			baud_cnt_q    <= baud_cnt_q + 13'h0001;
			baud_tick_out <= 1'b0;
		end
	end

	// character slots: start, eight data, stop, no parity
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in || rate_write)
		begin
			frame_bit_q   <= 4'h0;
			char_slot_out <= 1'b0;
		end
		else if (baud_tick_out)
		begin
			if (frame_bit_q == ccb_pkg::FRAME_BITS - 4'h1)
			begin
				frame_bit_q   <= 4'h0;
				char_slot_out <= 1'b1;
			end
			else
			begin
				frame_bit_q   <= frame_bit_q + 4'h1;
				char_slot_out <= 1'b0;
			end
		end
		else
			char_slot_out <= 1'b0;
	end

	// oscillator trim and PLL settings to the analog side
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			osc_freq_code_out       <= ~ccb_pkg::RESET_SLOW_OSC_TRIM;
			pll_power_down_out      <= 1'b0;
			pll_feedback_factor_out <= ccb_pkg::FEEDBACK_FACTOR_0;
			pll_output_factor_out   <= ccb_pkg::RESET_PLL_POST_DIVIDER;
			pll_div_reserved_out    <= 1'b0;
			pll_clock_valid_out     <= 1'b0;
		end
		else
		begin
			osc_freq_code_out  <= ~slow_oscillator_trim_q;
			pll_power_down_out <= pll_power_down;
			pll_feedback_factor_out <= ccb_feedback(
				pll_and_clock_pin_control_q[ccb_pkg::FEEDBACK_MSB:0]);
			pll_output_factor_out <= pll_post_divider_q;
			pll_div_reserved_out  <=
				(pll_post_divider_q < ccb_pkg::POST_DIVIDER_MIN) ||
				(pll_post_divider_q > ccb_pkg::POST_DIVIDER_MAX);
			pll_clock_valid_out <= !pll_power_down &&
				(pll_post_divider_q >= ccb_pkg::POST_DIVIDER_MIN) &&
				(pll_post_divider_q <= ccb_pkg::POST_DIVIDER_MAX);
		end
	end

	// analog PLL clock and overflow pulses into this domain
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			pll_sync1_q      <= 1'b0;
			pll_sync2_q      <= 1'b0;
			overflow_sync1_q <= 4'h0;
			overflow_sync2_q <= 4'h0;
			overflow_prev_q  <= 4'h0;
		end
		else
		begin
			pll_sync1_q      <= pll_clk_in;
			pll_sync2_q      <= pll_sync1_q;
			overflow_sync1_q <= counter_overflow_in;
			overflow_sync2_q <= overflow_sync1_q;
			overflow_prev_q  <= overflow_sync2_q;
		end
	end

	// crystal dividers
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
			xtal_div_q <= 4'h0;
		else
			xtal_div_q <= xtal_div_q + 4'h1;
	end

	// toggle on rising edge of the selected counter overflow
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
			overflow_toggle_q <= 1'b0;
		else if (clock_pin_source_select >= ccb_pkg::SEL_COUNTER_0 &&
			clock_pin_source_select <= ccb_pkg::SEL_COUNTER_3)
		begin
			if (overflow_sync2_q[clock_pin_source_select[1:0]] &&
				!overflow_prev_q[clock_pin_source_select[1:0]])
				overflow_toggle_q <= !overflow_toggle_q;
		end
	end

	// clock pin source selection
	always_comb
	begin
		pin_level_d = 1'b0;
		pin_oe_d    = 1'b1;
		case (clock_pin_source_select)
			ccb_pkg::SEL_PIN_IO:
				pin_oe_d = 1'b0;
			ccb_pkg::SEL_PLL:
				pin_level_d = pll_sync2_q && !pll_power_down;
			ccb_pkg::SEL_HOLD_LOW:
				pin_level_d = 1'b0;
			ccb_pkg::SEL_HOLD_HIGH:
				pin_level_d = 1'b1;
			4'h4:
				pin_level_d = !clock_output_pin_out;
			4'h5:
				pin_level_d = xtal_div_q[1];
			4'h6:
				pin_level_d = xtal_div_q[2];
			4'h7:
				pin_level_d = xtal_div_q[3];
			4'h8, 4'h9, 4'hA, 4'hB:
				pin_level_d = overflow_toggle_q;
			default:
				pin_oe_d = 1'b0;
		endcase
		if (clock_pin_source_select != ccb_pkg::SEL_HOLD_LOW &&
			clock_pin_source_select != ccb_pkg::SEL_HOLD_HIGH &&
			!clock_pin_output_enable)
			pin_level_d = 1'b0;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			clock_output_pin_out    <= 1'b0;
			clock_output_pin_oe_out <= 1'b0;
		end
		else
		begin
			clock_output_pin_out    <= pin_level_d;
			clock_output_pin_oe_out <= pin_oe_d;
		end
	end

	// helper: cycles between ticks under a settled rate
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in || rate_write)
		begin
			gap_q        <= 13'h0001;
			rate_fresh_q <= 1'b1;
		end
		else if (baud_tick_out)
		begin
			gap_q        <= 13'h0001;
			rate_fresh_q <= 1'b0;
		end
		else
			gap_q <= gap_q + 13'h0001;
	end

	property p_reset_rate;
		@(posedge core_clk_in)
		$past(reset_in) && !reset_in && !$past(reg_wr_in, 1) |->
			host_serial_rate_q == 8'h7A;
	endproperty
	a_reset_rate: assert property (p_reset_rate)
		else $error("serial rate not 7Ah after reset");

	property p_bit_period;
		@(posedge core_clk_in) disable iff (reset_in)
		baud_tick_out && !rate_fresh_q && !rate_write |->
			gap_q == rate_period;
	endproperty
	a_bit_period: assert property (p_bit_period)
		else $error("bit period does not match rate code");

	property p_frame_ten;
		@(posedge core_clk_in) disable iff (reset_in || rate_write)
		char_slot_out |-> frame_bit_q == 4'h0 && $past(frame_bit_q) == 4'h9;
	endproperty
	a_frame_ten: assert property (p_frame_ten)
		else $error("character slot not after ten bits");

	property p_trim_inverse;
		@(posedge core_clk_in) disable iff (reset_in)
		##1 osc_freq_code_out == 8'(~$past(slow_oscillator_trim_q));
	endproperty
	a_trim_inverse: assert property (p_trim_inverse)
		else $error("trim does not lower the frequency code");

	property p_feedback;
		@(posedge core_clk_in) disable iff (reset_in)
		$past(pll_and_clock_pin_control_q[1:0]) == 2'h2 && !$past(reset_in)
			|-> pll_feedback_factor_out == 5'h1C;
	endproperty
	a_feedback: assert property (p_feedback)
		else $error("feedback setting 10 not factor 28");

	property p_div_reserved;
		@(posedge core_clk_in) disable iff (reset_in)
		reg_wr_in && reg_addr_in == 8'h3E && reg_wdata_in == 8'h07 ##1
			!reg_wr_in |=> pll_div_reserved_out && !pll_clock_valid_out;
	endproperty
	a_div_reserved: assert property (p_div_reserved)
		else $error("reserved output divider not flagged");

	property p_power_down;
		@(posedge core_clk_in) disable iff (reset_in)
		pll_power_down && clock_pin_source_select == 4'h1 |-> ##1
			!clock_output_pin_out && !pll_clock_valid_out;
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("PLL clock shown while powered down");

	property p_hold_levels;
		@(posedge core_clk_in) disable iff (reset_in)
		clock_pin_source_select == 4'h3 [*2] |->
			clock_output_pin_out && clock_output_pin_oe_out;
	endproperty
	a_hold_levels: assert property (p_hold_levels)
		else $error("hold-high select not driving high");

	property p_pin_gate;
		@(posedge core_clk_in) disable iff (reset_in)
		!clock_pin_output_enable && clock_pin_source_select == 4'h4 |=>
			!clock_output_pin_out;
	endproperty
	a_pin_gate: assert property (p_pin_gate)
		else $error("clock reached pin while gated off");

	property p_div1_toggle;
		@(posedge core_clk_in) disable iff (reset_in)
		(clock_pin_output_enable && clock_pin_source_select == 4'h4) [*3]
			|-> clock_output_pin_out != $past(clock_output_pin_out);
	endproperty
	a_div1_toggle: assert property (p_div1_toggle)
		else $error("divide-by-one source not toggling");

	property p_reserved_sel;
		@(posedge core_clk_in) disable iff (reset_in)
		clock_pin_source_select >= 4'hC |=> !clock_output_pin_oe_out;
	endproperty
	a_reserved_sel: assert property (p_reserved_sel)
		else $error("reserved select drives the pin");

endmodule : ccb_clock_config

// ==== rtl/ccb_pkg.sv ====
// constants for the clock configuration block
// Summary of operation
// - host serial rate register loads 7Ah at reset.
// - exponent zero: bit period is mantissa plus one crystal cycles.
// - exponent nonzero: period is (mantissa+33) << (exponent-1).
// - a character is one start bit, eight data bits, one stop bit.
// - no parity bit in any character, either direction.
// - a larger oscillator trim value lowers the slow oscillator frequency.
// - PLL first stage multiplies input by feedback factor, then halves.
// - PLL second stage divides by the eight-bit output divider value.
// - pin select 0h releases pin, 2h holds low, 3h holds high.
// - pin select 1h routes the analog PLL output to the pin.
// - pin select 4h to 7h shows crystal divided by 1, 2, 4, 8.
// - pin select 8h to Bh toggles on counter overflows; Ch-Fh reserved.
// - control bit 3 gates whether the selected clock reaches the pin.
// - feedback setting 00,01,10,11 selects factor 23, 27, 28, 23.
// - output divider 0 to 7 reserved; 8 to 254 divide exactly.
package ccb_pkg;

	localparam logic [7:0] ADDR_HOST_SERIAL_RATE  = 8'h3B;
	localparam logic [7:0] ADDR_SLOW_OSC_TRIM     = 8'h3C;
	localparam logic [7:0] ADDR_PLL_PIN_CONTROL   = 8'h3D;
	localparam logic [7:0] ADDR_PLL_POST_DIVIDER  = 8'h3E;

	localparam logic [7:0] RESET_HOST_SERIAL_RATE = 8'h7A;
	localparam logic [7:0] RESET_SLOW_OSC_TRIM    = 8'h00;
	localparam logic [7:0] RESET_PLL_PIN_CONTROL  = 8'h00;
	localparam logic [7:0] RESET_PLL_POST_DIVIDER = 8'h08;
	localparam logic [7:0] UNMAPPED_READ_VALUE    = 8'h00;

	localparam int EXPONENT_MSB    = 7;
	localparam int EXPONENT_LSB    = 5;
	localparam int MANTISSA_MSB    = 4;
	localparam int SELECT_MSB      = 7;
	localparam int SELECT_LSB      = 4;
	localparam int PIN_ENABLE_BIT  = 3;
	localparam int POWER_DOWN_BIT  = 2;
	localparam int FEEDBACK_MSB    = 1;

	localparam logic [5:0]  MANTISSA_OFFSET_SMALL = 6'h01;
	localparam logic [6:0]  MANTISSA_OFFSET_LARGE = 7'h21;
	localparam logic [3:0]  FRAME_BITS            = 4'hA;
	localparam logic [7:0]  POST_DIVIDER_MIN      = 8'h08;
	localparam logic [7:0]  POST_DIVIDER_MAX      = 8'hFE;

	localparam logic [4:0] FEEDBACK_FACTOR_0 = 5'h17;
	localparam logic [4:0] FEEDBACK_FACTOR_1 = 5'h1B;
	localparam logic [4:0] FEEDBACK_FACTOR_2 = 5'h1C;
	localparam logic [4:0] FEEDBACK_FACTOR_3 = 5'h17;

	localparam logic [3:0] SEL_PIN_IO       = 4'h0;
	localparam logic [3:0] SEL_PLL          = 4'h1;
	localparam logic [3:0] SEL_HOLD_LOW     = 4'h2;
	localparam logic [3:0] SEL_HOLD_HIGH    = 4'h3;
	localparam logic [3:0] SEL_XTAL_DIV1    = 4'h4;
	localparam logic [3:0] SEL_XTAL_DIV8    = 4'h7;
	localparam logic [3:0] SEL_COUNTER_0    = 4'h8;
	localparam logic [3:0] SEL_COUNTER_3    = 4'hB;

endpackage : ccb_pkg

// ==== tb/ccb_clock_config_tb_top.sv ====
// self-checking testbench for the clock configuration block
`timescale 1ns/1ns
`define CCB_CHK(act, exp) \
	begin \
		checked++; \
		if ((act) !== (exp)) \
		begin \
			n_errors++; \
			$display("Error at %0t ns: got %0h expected %0h", \
				$time, (act), (exp)); \
		end \
	end
module ccb_clock_config_tb_top;
	logic       clk = 1'h0;
	logic       rst = 1'h1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'h0;
	logic       rd = 1'h0;
	logic       pll_clk = 1'h0;
	logic [3:0] ovf = 4'h0;
	logic [7:0] rdata;
	logic       tick;
	logic       slot;
	logic [7:0] osc;
	logic       pd;
	logic       valid;
	logic [4:0] fb;
	logic [7:0] outf;
	logic       res;
	logic       pin;
	logic       oe;
	int         n_errors = 0;
	int         checked = 0;

	ccb_clock_config dut_u
	(
		.core_clk_in             (clk),
		.reset_in                (rst),
		.reg_addr_in             (addr),
		.reg_wdata_in            (wdata),
		.reg_wr_in               (wr),
		.reg_rd_in               (rd),
		.pll_clk_in              (pll_clk),
		.counter_overflow_in     (ovf),
		.reg_rdata_out           (rdata),
		.baud_tick_out           (tick),
		.char_slot_out           (slot),
		.osc_freq_code_out       (osc),
		.pll_power_down_out      (pd),
		.pll_clock_valid_out     (valid),
		.pll_feedback_factor_out (fb),
		.pll_output_factor_out   (outf),
		.pll_div_reserved_out    (res),
		.clock_output_pin_out    (pin),
		.clock_output_pin_oe_out (oe)
	);

	always #20 clk = ~clk;

	task automatic final_report();
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'h1;
		@(negedge clk);
		wr = 1'h0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'h1;
		@(negedge clk);
		rd = 1'h0;
		@(negedge clk);
		d = rdata;
	endtask : rd_reg

	task automatic t_reset_values();
		logic [7:0] d;
		`CCB_CHK(osc, 8'hFF)
		`CCB_CHK(fb, 5'h17)
		`CCB_CHK(oe, 1'h0)
		rd_reg(8'h3B, d);
		`CCB_CHK(d, 8'h7A)
		wr_reg(8'h3F, 8'h5A);
		rd_reg(8'h3F, d);
		`CCB_CHK(d, 8'h00)
	endtask : t_reset_values

	// bit period, first ticks and character slot after a rate write
	task automatic t_rate(input logic [7:0] code);
		int p;
		int cnt;
		int t1;
		int t2;
		int ts;
		int nt;
		logic [7:0] d;
		if (code[7:5] == 3'h0)
			p = int'(code[4:0]) + 1;
		else
			p = (int'(code[4:0]) + 33) << (int'(code[7:5]) - 1);
		t1 = 0;
		t2 = 0;
		ts = 0;
		nt = 0;
		wr_reg(8'h3B, code);
		for (cnt = 1; cnt <= 10 * p + 4 && ts == 0; cnt++)
		begin
			@(negedge clk);
			if (slot === 1'h1)
				ts = cnt;
			else if (tick === 1'h1)
			begin
				nt++;
				if (nt == 1)
					t1 = cnt;
				if (nt == 2)
					t2 = cnt;
			end
		end
		`CCB_CHK(t1, p)
		`CCB_CHK(t2, 2 * p)
		`CCB_CHK(nt, 10)
		`CCB_CHK(ts, 10 * p + 1)
		rd_reg(8'h3B, d);
		`CCB_CHK(d, code)
	endtask : t_rate

	task automatic t_trim();
		logic [7:0] v [3] = '{8'h10, 8'h20, 8'hFF};
		logic [7:0] prev;
		prev = osc;
		foreach (v[i])
		begin
			wr_reg(8'h3C, v[i]);
			repeat (2) @(negedge clk);
			`CCB_CHK(osc, ~v[i])
			`CCB_CHK(osc < prev, 1'h1)
			prev = osc;
		end
	endtask : t_trim

	task automatic t_pll();
		logic [4:0] fx [4] = '{5'h17, 5'h1B, 5'h1C, 5'h17};
		logic [7:0] dv [4] = '{8'h07, 8'h08, 8'hFE, 8'hFF};
		logic       rx [4] = '{1'h1, 1'h0, 1'h0, 1'h1};
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(8'h3D, {6'h00, 2'(i)});
			repeat (2) @(negedge clk);
			`CCB_CHK(fb, fx[i])
		end
		foreach (dv[i])
		begin
			wr_reg(8'h3E, dv[i]);
			repeat (2) @(negedge clk);
			`CCB_CHK(outf, dv[i])
			`CCB_CHK(res, rx[i])
			`CCB_CHK(valid, ~rx[i])
		end
		wr_reg(8'h3E, 8'h08);
		wr_reg(8'h3D, 8'h04);
		repeat (2) @(negedge clk);
		`CCB_CHK({pd, valid}, 2'h2)
	endtask : t_pll

	// half period of a crystal-derived pin clock
	task automatic t_xtal(input logic [3:0] sel, input int half);
		int   cnt;
		logic last;
		wr_reg(8'h3D, {sel, 4'h8});
		repeat (20) @(negedge clk);
		`CCB_CHK(oe, 1'h1)
		last = pin;
		cnt = 0;
		while (pin === last && cnt < 40)
		begin
			@(negedge clk);
			cnt++;
		end
		last = pin;
		cnt = 0;
		while (pin === last && cnt < 40)
		begin
			@(negedge clk);
			cnt++;
		end
		`CCB_CHK(cnt, half)
	endtask : t_xtal

	task automatic t_pin();
		logic last;
		wr_reg(8'h3D, 8'h08);
		repeat (4) @(negedge clk);
		`CCB_CHK(oe, 1'h0)
		wr_reg(8'h3D, 8'h20);
		repeat (4) @(negedge clk);
		`CCB_CHK({oe, pin}, 2'h2)
		wr_reg(8'h3D, 8'h30);
		repeat (4) @(negedge clk);
		`CCB_CHK({oe, pin}, 2'h3)
		wr_reg(8'h3D, 8'hC8);
		repeat (4) @(negedge clk);
		`CCB_CHK(oe, 1'h0)
		for (int s = 4; s < 8; s++)
			t_xtal(4'(s), 1 << (s - 4));
		wr_reg(8'h3D, 8'h40);
		repeat (4)
		begin
			@(negedge clk);
			`CCB_CHK(pin, 1'h0)
		end
		for (int k = 0; k < 4; k++)
		begin
			wr_reg(8'h3D, {4'(8 + k), 4'h8});
			repeat (4) @(negedge clk);
			last = pin;
			ovf[(k + 1) % 4] = 1'h1;
			repeat (2) @(negedge clk);
			ovf = 4'h0;
			repeat (6) @(negedge clk);
			`CCB_CHK(pin, last)
			ovf[k] = 1'h1;
			repeat (2) @(negedge clk);
			ovf = 4'h0;
			repeat (6) @(negedge clk);
			`CCB_CHK(pin, ~last)
		end
		wr_reg(8'h3D, 8'h18);
		pll_clk = 1'h1;
		repeat (6) @(negedge clk);
		`CCB_CHK({oe, pin, valid}, 3'h7)
		pll_clk = 1'h0;
		repeat (6) @(negedge clk);
		`CCB_CHK(pin, 1'h0)
		wr_reg(8'h3D, 8'h1C);
		pll_clk = 1'h1;
		repeat (6) @(negedge clk);
		`CCB_CHK({pin, valid}, 2'h0)
	endtask : t_pin

	initial
	begin
		#(60000 * 40);
		n_errors++;
		final_report();
	end

	initial
	begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		t_reset_values();
		t_rate(8'h1F);
		t_rate(8'h15);
		t_rate(8'h1C);
		t_rate(8'h21);
		t_rate(8'h40);
		t_rate(8'h7A);
		t_rate(8'hE0);
		t_trim();
		t_pll();
		t_pin();
		final_report();
	end
endmodule : ccb_clock_config_tb_top
